// ===== src/icc_regs.vh
// register map, field positions, reset values and mode codes of the
// input capture channel; assumes an apb slave with 32-bit data words
`ifndef ICC_REGS_VH
`define ICC_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ICC_OFS_CONTROL      8'h00
`define ICC_OFS_BUFFER       8'h04
`define ICC_OFS_IRQ_STATUS   8'h08
`define ICC_OFS_IRQ_MASK     8'h0C

// ****************************************************************
// control register fields
// ****************************************************************
`define ICC_BIT_IDLE_STOP    13
`define ICC_POS_TB_HI        12
`define ICC_POS_TB_LO        10
`define ICC_POS_CPI_HI       6
`define ICC_POS_CPI_LO       5
`define ICC_BIT_OVERFLOW     4
`define ICC_BIT_NOT_EMPTY    3
`define ICC_POS_MODE_HI      2
`define ICC_POS_MODE_LO      0
`define ICC_CTRL_WR_MASK     16'h3C67
`define ICC_CTRL_RESET       16'h0000

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define ICC_IRQ_CAPTURE      0
`define ICC_IRQ_OVERFLOW     1
`define ICC_IRQ_WIDTH        2
`define ICC_IRQ_RESET        2'b00

// ****************************************************************
// capture mode codes
// ****************************************************************
`define ICC_MODE_OFF         3'b000
`define ICC_MODE_ANY_EDGE    3'b001
`define ICC_MODE_FALL        3'b010
`define ICC_MODE_RISE        3'b011
`define ICC_MODE_RISE4       3'b100
`define ICC_MODE_RISE16      3'b101
`define ICC_MODE_UNUSED      3'b110
`define ICC_MODE_WAKE_PIN    3'b111

// ****************************************************************
// timebase select codes
// ****************************************************************
`define ICC_TB_TIMER3        3'b000
`define ICC_TB_TIMER2        3'b001
`define ICC_TB_TIMER4        3'b010
`define ICC_TB_TIMER5        3'b011
`define ICC_TB_TIMER1        3'b100
`define ICC_TB_PERIPH        3'b111

// ****************************************************************
// prescaler terminal counts
// ****************************************************************
`define ICC_PRE4_LAST        4'h3
`define ICC_PRE16_LAST       4'hF

`endif

// ===== src/icc_sync.v
// three-stage synchroniser for the capture pin with agreement filter
// assumes the pin is asynchronous to i_clk
`timescale 1ns/1ns
`default_nettype none

module icc_sync (
   input  wire i_clk,
   input  wire i_resetn,
   input  wire i_pin,
   output reg  o_level
);

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // ****************************************************************
   // sync chain; level follows once stages two and three agree
   // ****************************************************************
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            o_level <= s3_reg;
         end
      end
   end

endmodule

`default_nettype wire

// ===== src/icc_top.v
// input capture channel with apb register access and interrupt
// assumes timer counts are synchronous to i_clk; pin is asynchronous
// Behaviour
// - idle stop bit set halts the channel in cpu idle, else it runs
// - timebase field picks peripheral clock or timers one to five
// - timer1 timebase is taken as a synchronous count only
// - interrupt every first, second, third or fourth capture
// - captures per interrupt ignored in any-edge and wake-pin modes
// - overflow flag read only, set on buffer overflow, else clear
// - not-empty flag read only, set while buffer holds a value
// - mode 011 captures rising edges, 010 falling edges
// - mode 100 every fourth rising edge, 101 every sixteenth
// - mode 001 captures every edge, no captures per interrupt
// - mode 111 makes the pin a rising-edge wake interrupt only
// - modes 000 and 110 leave the channel disabled
// - unimplemented control bits read zero and ignore writes
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "icc_regs.vh"

module icc_top #(
   parameter CNT_W   = 16,
   parameter DEPTH   = 4,
   parameter PTR_W   = 2
) (
   input  wire             i_clk,
   input  wire             i_resetn,
   input  wire             i_psel,
   input  wire             i_penable,
   input  wire             i_pwrite,
   input  wire [7:0]       i_paddr,
   input  wire [31:0]      i_pwdata,
   output reg  [31:0]      o_prdata,
   output reg              o_pready,
   output reg              o_pslverr,
   input  wire             i_capture_pin,
   input  wire             i_cpu_idle,
   input  wire             i_cpu_sleep,
   input  wire [CNT_W-1:0] i_timer1_count,
   input  wire [CNT_W-1:0] i_timer2_count,
   input  wire [CNT_W-1:0] i_timer3_count,
   input  wire [CNT_W-1:0] i_timer4_count,
   input  wire [CNT_W-1:0] i_timer5_count,
   output reg              o_irq
);

   // ****************************************************************
   // functions
   // ****************************************************************
   function [PTR_W-1:0] ptr_inc;
      input [PTR_W-1:0] p;
      begin
         if (p == DEPTH - 1) begin
            ptr_inc = {PTR_W{1'b0}};
         end else begin
            ptr_inc = p + 1'b1;
         end
      end
   endfunction

   function is_offset;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         is_offset = (addr[7:2] == ofs[7:2]);
      end
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg  [15:0]       ctrl_reg;
   reg  [CNT_W-1:0]  periph_cnt_reg;
   reg               level_reg;
   reg  [3:0]        pre_cnt_reg;
   reg  [1:0]        cpi_cnt_reg;
   reg  [CNT_W-1:0]  mem_reg [0:DEPTH-1];
   reg  [PTR_W-1:0]  wr_ptr_reg;
   reg  [PTR_W-1:0]  rd_ptr_reg;
   reg  [PTR_W:0]    count_reg;
   reg               ovf_reg;
   reg  [`ICC_IRQ_WIDTH-1:0] stat_reg;
   reg  [`ICC_IRQ_WIDTH-1:0] mask_reg;
   reg  [CNT_W-1:0]  tb_count;
   reg               capture;
   reg               cap_irq;
   reg  [31:0]       rdata_next;
   reg               err_next;
   wire              pin_level;
   wire [2:0]        mode;
   wire [2:0]        tb_sel;
   wire [1:0]        cpi;
   wire              rise;
   wire              fall;
   wire              halted;
   wire              done;
   wire              wr_en;
   wire              rd_pop;
   wire              full;
   wire              empty;
   wire              push;
   wire              ctrl_wr;

   assign mode   = ctrl_reg[`ICC_POS_MODE_HI:`ICC_POS_MODE_LO];
   assign tb_sel = ctrl_reg[`ICC_POS_TB_HI:`ICC_POS_TB_LO];
   assign cpi    = ctrl_reg[`ICC_POS_CPI_HI:`ICC_POS_CPI_LO];
   assign rise   = pin_level & ~level_reg;
   assign fall   = ~pin_level & level_reg;
   assign full   = (count_reg == DEPTH);
   assign empty  = (count_reg == {(PTR_W+1){1'b0}});

   // ****************************************************************
   // pin synchroniser
   // ****************************************************************
   icc_sync u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pin    (i_capture_pin),
      .o_level  (pin_level)
   );

   // ****************************************************************
   // apb handshake
   // ****************************************************************
   assign done    = i_psel & i_penable & o_pready;
   assign wr_en   = done & i_pwrite;
   assign rd_pop  = done & ~i_pwrite & is_offset(i_paddr, `ICC_OFS_BUFFER)
                    & ~empty;
   assign ctrl_wr = wr_en & is_offset(i_paddr, `ICC_OFS_CONTROL);

   always @* begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      if (is_offset(i_paddr, `ICC_OFS_CONTROL)) begin
         rdata_next[15:0] = ctrl_reg;
         rdata_next[`ICC_BIT_OVERFLOW]  = ovf_reg;
         rdata_next[`ICC_BIT_NOT_EMPTY] = ~empty;
      end else if (is_offset(i_paddr, `ICC_OFS_BUFFER)) begin
         if (!empty) begin
            rdata_next[CNT_W-1:0] = mem_reg[rd_ptr_reg];
         end
      end else if (is_offset(i_paddr, `ICC_OFS_IRQ_STATUS)) begin
         rdata_next[`ICC_IRQ_WIDTH-1:0] = stat_reg;
      end else if (is_offset(i_paddr, `ICC_OFS_IRQ_MASK)) begin
         rdata_next[`ICC_IRQ_WIDTH-1:0] = mask_reg;
      end else begin
         err_next = 1'b1;
      end
   end

   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel & i_penable & ~o_pready;
         o_prdata  <= rdata_next;
         o_pslverr <= i_psel & i_penable & ~o_pready & err_next;
      end
   end

   // ****************************************************************
   // control register
   // ****************************************************************
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= `ICC_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_reg <= i_pwdata[15:0] & `ICC_CTRL_WR_MASK;
      end
   end

   // ****************************************************************
   // timebase selection
   // ****************************************************************
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         periph_cnt_reg <= {CNT_W{1'b0}};
      end else begin
         periph_cnt_reg <= periph_cnt_reg + 1'b1;
      end
   end

   always @* begin
      tb_count = {CNT_W{1'b0}};
      case (tb_sel)
         `ICC_TB_PERIPH: tb_count = periph_cnt_reg;
         `ICC_TB_TIMER1: tb_count = i_timer1_count;
         `ICC_TB_TIMER5: tb_count = i_timer5_count;
         `ICC_TB_TIMER4: tb_count = i_timer4_count;
         `ICC_TB_TIMER2: tb_count = i_timer2_count;
         `ICC_TB_TIMER3: tb_count = i_timer3_count;
         default:        tb_count = {CNT_W{1'b0}};
      endcase
   end

   // ****************************************************************
   // edge qualification
   // ****************************************************************
   assign halted = (i_cpu_idle & ctrl_reg[`ICC_BIT_IDLE_STOP])
                   | i_cpu_sleep;

   always @* begin
      capture = 1'b0;
      case (mode)
         `ICC_MODE_ANY_EDGE: capture = rise | fall;
         `ICC_MODE_RISE:     capture = rise;
         `ICC_MODE_FALL:     capture = fall;
         `ICC_MODE_RISE4:    capture = rise & (pre_cnt_reg == `ICC_PRE4_LAST);
         `ICC_MODE_RISE16:   capture = rise & (pre_cnt_reg == `ICC_PRE16_LAST);
         default:            capture = 1'b0;
      endcase
      if (halted) begin
         capture = 1'b0;
      end
   end

   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         level_reg   <= 1'b0;
         pre_cnt_reg <= 4'h0;
      end else begin
         level_reg <= pin_level;
         if (ctrl_wr) begin
            pre_cnt_reg <= 4'h0;
         end else if (rise && !halted) begin
            if ((mode == `ICC_MODE_RISE4 && pre_cnt_reg == `ICC_PRE4_LAST)
                || mode != `ICC_MODE_RISE4 && mode != `ICC_MODE_RISE16) begin
               pre_cnt_reg <= 4'h0;
            end else begin
               pre_cnt_reg <= pre_cnt_reg + 4'h1;
            end
         end
      end
   end

   // ****************************************************************
   // captures per interrupt
   // ****************************************************************
   always @* begin
      cap_irq = 1'b0;
      if (mode == `ICC_MODE_WAKE_PIN) begin
         cap_irq = rise & (i_cpu_sleep | i_cpu_idle);
      end else if (capture) begin
         if (mode == `ICC_MODE_ANY_EDGE) begin
            cap_irq = 1'b1;
         end else begin
            cap_irq = (cpi_cnt_reg == cpi);
         end
      end
   end

   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cpi_cnt_reg <= 2'b00;
      end else if (ctrl_wr) begin
         cpi_cnt_reg <= 2'b00;
      end else if (capture && mode != `ICC_MODE_ANY_EDGE) begin
         if (cpi_cnt_reg == cpi) begin
            cpi_cnt_reg <= 2'b00;
         end else begin
            cpi_cnt_reg <= cpi_cnt_reg + 2'b01;
         end
      end
   end

   // ****************************************************************
   // capture buffer
   // ****************************************************************
   assign push = capture & ~full;

   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_reg <= {PTR_W{1'b0}};
         rd_ptr_reg <= {PTR_W{1'b0}};
         count_reg  <= {(PTR_W+1){1'b0}};
      end else if (mode == `ICC_MODE_OFF || mode == `ICC_MODE_UNUSED) begin
         wr_ptr_reg <= {PTR_W{1'b0}};
         rd_ptr_reg <= {PTR_W{1'b0}};
         count_reg  <= {(PTR_W+1){1'b0}};
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= tb_count;
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (rd_pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         if (push && !rd_pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (rd_pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ovf_reg <= 1'b0;
      end else if (capture && full) begin
         ovf_reg <= 1'b1;
      end else if (mode == `ICC_MODE_OFF || mode == `ICC_MODE_UNUSED) begin
         ovf_reg <= 1'b0;
      end else if (rd_pop && count_reg == 1) begin
         ovf_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // interrupt status, mask and output
   // ****************************************************************
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         stat_reg <= `ICC_IRQ_RESET;
         mask_reg <= `ICC_IRQ_RESET;
         o_irq    <= 1'b0;
      end else begin
         if (wr_en && is_offset(i_paddr, `ICC_OFS_IRQ_MASK)) begin
            mask_reg <= i_pwdata[`ICC_IRQ_WIDTH-1:0];
         end
         if (wr_en && is_offset(i_paddr, `ICC_OFS_IRQ_STATUS)) begin
            stat_reg <= (stat_reg & ~i_pwdata[`ICC_IRQ_WIDTH-1:0])
                        | {capture & full, cap_irq};
         end else begin
            stat_reg <= stat_reg | {capture & full, cap_irq};
         end
         o_irq <= |(stat_reg & mask_reg);
      end
   end

endmodule

`default_nettype wire

// ===== verification/icc_pin_model.sv
// pin driver standing in for the external signal on the capture pin
// assumes the bench calls pulses() from one process at a time
`timescale 1ns/1ns
`default_nettype none

module icc_pin_model (
   input  wire logic i_clk,
   output var  logic o_pin
);
   // ****
   // pulse generator
   // ****
   initial o_pin = 1'b0;

   // idle low; each pulse is long enough to pass the agreement filter
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_pin <= 1'b1;
         repeat (6) @(posedge i_clk);
         o_pin <= 1'b0;
         repeat (5) @(posedge i_clk);
      end
      repeat (8) @(posedge i_clk);
   endtask
endmodule

`default_nettype wire

// ===== verification/icc_top_properties.sv
// concurrent checks on the capture channel's bus and status replies
// assumes it is bound to icc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module icc_top_properties (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] o_prdata,
   input  wire logic        o_pready,
   input  wire logic        o_pslverr,
   input  wire logic        o_irq
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire logic rd_ok = o_pready && !i_pwrite && i_paddr[7:4] == 4'h0;

   a_ready_one_cycle: assert property (o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");
   a_ready_after_access: assert property (
      $rose(i_penable) && i_psel |=> o_pready)
      else $error("pready late after access phase");
   a_ready_needs_req: assert property (
      o_pready |-> $past(i_psel && i_penable))
      else $error("pready without access phase");
   a_unmapped_error: assert property (o_pready && i_paddr[7:4] != 4'h0
      |-> o_pslverr && o_prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (
      o_pready && i_paddr[7:4] == 4'h0 |-> !o_pslverr)
      else $error("mapped access refused");
   a_ctrl_unused_zero: assert property (
      rd_ok && i_paddr[3:2] == 2'b00
      |-> o_prdata[31:14] == 18'h0 && o_prdata[9:7] == 3'h0)
      else $error("unimplemented control bits not zero");
   a_ovf_needs_data: assert property (
      rd_ok && i_paddr[3:2] == 2'b00 && o_prdata[4] |-> o_prdata[3])
      else $error("overflow shown with empty buffer");
   a_buffer_width: assert property (
      rd_ok && i_paddr[3:2] == 2'b01 |-> o_prdata[31:16] == 16'h0)
      else $error("buffer read wider than count");
   a_irq_fall_cause: assert property (
      $fell(o_irq) |-> $past(o_pready && i_pwrite, 2))
      else $error("interrupt dropped without a write");
endmodule

bind icc_top icc_top_properties u_props (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_irq(o_irq));

`default_nettype wire

// ===== verification/test_input_capture_control.sv
// self-checking bench for the input capture channel
// assumes icc_top, its checker and the pin model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "icc_regs.vh"

module test_input_capture_control;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        idle = 1'b0;
   logic        sleep = 1'b0;
   logic [15:0] t1, t2, t3;
   logic [15:0] t4, t5;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, pin;
   int          err_count = 0, checked = 0, cyc = 0;

   always #50 clk = ~clk;

   icc_top DUT (.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_capture_pin(pin), .i_cpu_idle(idle),
      .i_cpu_sleep(sleep), .i_timer1_count(t1), .i_timer2_count(t2),
      .i_timer3_count(t3), .i_timer4_count(t4), .i_timer5_count(t5),
      .o_irq(irq));
   icc_pin_model PIN (.i_clk(clk), .o_pin(pin));

   // ****
   // bus and compare tasks
   // ****
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) cmp(32'h0000_0000, 32'h0000_0001);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // timer counts held steady per capture, distinct per timer
   task set_timers(input logic [15:0] b);
      t1 <= 16'h1000 + b;
      t2 <= 16'h2000 + b;
      t3 <= 16'h3000 + b;
      t4 <= 16'h4000 + b;
      t5 <= 16'h5000 + b;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(a, 1'b1, d, r, e);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(a, 1'b0, 32'h0000_0000, r, e);
   endtask

   task drain(output int c);
      logic [31:0] r;
      c = 0;
      repeat (6) begin
         rd(`ICC_OFS_CONTROL, r);
         if (r[`ICC_BIT_NOT_EMPTY] === 1'b1) begin
            rd(`ICC_OFS_BUFFER, r);
            c++;
         end
      end
   endtask

   // ****
   // scenarios
   // ****
   task t_regs;
      logic [31:0] r;
      logic        e;
      rd(`ICC_OFS_CONTROL, r);
      cmp(r, 32'h0000_0000);
      wr(`ICC_OFS_CONTROL, 32'hFFFF_FFFF);
      rd(`ICC_OFS_CONTROL, r);
      cmp(r, 32'h0000_3C67);
      wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      apb(8'h40, 1'b1, 32'hFFFF_FFFF, r, e);
      cmp(e, 32'h0000_0001);
      apb(8'h10, 1'b0, 32'h0000_0000, r, e);
      cmp(r, 32'h0000_0000);
      cmp(e, 32'h0000_0001);
      rd(`ICC_OFS_IRQ_MASK, r);
      cmp(r, 32'h0000_0000);
      $display("register test done");
   endtask

   task t_timebase;
      logic [15:0] ev [7];
      logic [31:0] r, q;
      ev = '{16'h3000, 16'h2000, 16'h4000, 16'h5000, 16'h1000, 16'h0000,
         16'h0000};
      for (int i = 0; i < 7; i++) begin
         set_timers(16'(i));
         wr(`ICC_OFS_CONTROL, (i << 10) | `ICC_MODE_RISE);
         PIN.pulses(1);
         rd(`ICC_OFS_CONTROL, r);
         cmp(r & 32'h0000_0008, 32'h0000_0008);
         rd(`ICC_OFS_BUFFER, r);
         q = (i < 5) ? {16'h0000, ev[i] + 16'(i)} : 32'h0000_0000;
         cmp(r, q);
         wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      end
      // peripheral clock: rising edges of pulses(2) lie 12 cycles apart
      wr(`ICC_OFS_CONTROL, 32'h0000_1C00 | `ICC_MODE_RISE);
      PIN.pulses(2);
      rd(`ICC_OFS_BUFFER, r);
      rd(`ICC_OFS_BUFFER, q);
      cmp((q - r) & 32'h0000_FFFF, 32'h0000_000C);
      wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      set_timers(16'h0000);
      $display("timebase test done");
   endtask

   task t_modes;
      logic [2:0] md [7];
      int         np [7];
      int         ex [7];
      int         c;
      md = '{`ICC_MODE_RISE, `ICC_MODE_FALL, `ICC_MODE_ANY_EDGE,
         `ICC_MODE_RISE4, `ICC_MODE_RISE16, `ICC_MODE_OFF, `ICC_MODE_UNUSED};
      np = '{3, 3, 2, 8, 16, 2, 2};
      ex = '{3, 3, 4, 2, 1, 0, 0};
      for (int i = 0; i < 7; i++) begin
         wr(`ICC_OFS_CONTROL, {29'h0, md[i]});
         PIN.pulses(np[i]);
         drain(c);
         cmp(c, ex[i]);
         wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      end
      wr(`ICC_OFS_IRQ_STATUS, 32'h0000_0003);
      $display("mode test done");
   endtask

   task t_overflow;
      logic [31:0] r;
      wr(`ICC_OFS_CONTROL, `ICC_MODE_RISE);
      for (int i = 0; i < 5; i++) begin
         t3 <= 16'hA000 + i;
         PIN.pulses(1);
      end
      rd(`ICC_OFS_CONTROL, r);
      cmp(r & 32'h0000_0018, 32'h0000_0018);
      rd(`ICC_OFS_IRQ_STATUS, r);
      cmp(r, 32'h0000_0003);
      for (int i = 0; i < 4; i++) begin
         rd(`ICC_OFS_BUFFER, r);
         cmp(r, 32'h0000_A000 + i);
      end
      rd(`ICC_OFS_CONTROL, r);
      cmp(r & 32'h0000_0018, 32'h0000_0000);
      rd(`ICC_OFS_BUFFER, r);
      cmp(r, 32'h0000_0000);
      wr(`ICC_OFS_IRQ_STATUS, 32'h0000_0003);
      rd(`ICC_OFS_IRQ_STATUS, r);
      cmp(r, 32'h0000_0000);
      t3 <= 16'h3333;
      wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      $display("overflow test done");
   endtask

   task t_irq;
      logic [31:0] r;
      wr(`ICC_OFS_IRQ_MASK, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         wr(`ICC_OFS_CONTROL, (k << 5) | `ICC_MODE_RISE);
         PIN.pulses(k);
         rd(`ICC_OFS_IRQ_STATUS, r);
         cmp(r, 32'h0000_0000);
         PIN.pulses(1);
         rd(`ICC_OFS_IRQ_STATUS, r);
         cmp(r, 32'h0000_0001);
         cmp(irq, 32'h0000_0001);
         wr(`ICC_OFS_CONTROL, 32'h0000_0000);
         wr(`ICC_OFS_IRQ_STATUS, 32'h0000_0001);
         repeat (2) @(posedge clk);
         cmp(irq, 32'h0000_0000);
      end
      wr(`ICC_OFS_CONTROL, 32'h0000_0060 | `ICC_MODE_ANY_EDGE);
      PIN.pulses(1);
      rd(`ICC_OFS_IRQ_STATUS, r);
      cmp(r, 32'h0000_0001);
      wr(`ICC_OFS_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      cmp(irq, 32'h0000_0000);
      wr(`ICC_OFS_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      cmp(irq, 32'h0000_0001);
      wr(`ICC_OFS_IRQ_STATUS, 32'h0000_0001);
      wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      $display("interrupt test done");
   endtask

   task t_power;
      logic [31:0] r;
      int          c;
      idle <= 1'b1;
      wr(`ICC_OFS_CONTROL, 32'h0000_2000 | `ICC_MODE_RISE);
      PIN.pulses(1);
      idle <= 1'b0;
      drain(c);
      cmp(c, 0);
      idle <= 1'b1;
      wr(`ICC_OFS_CONTROL, `ICC_MODE_RISE);
      PIN.pulses(1);
      idle <= 1'b0;
      drain(c);
      cmp(c, 1);
      wr(`ICC_OFS_IRQ_STATUS, 32'h0000_0001);
      wr(`ICC_OFS_CONTROL, 32'h0000_0060 | `ICC_MODE_WAKE_PIN);
      PIN.pulses(1);
      rd(`ICC_OFS_IRQ_STATUS, r);
      cmp(r, 32'h0000_0000);
      sleep <= 1'b1;
      PIN.pulses(1);
      rd(`ICC_OFS_IRQ_STATUS, r);
      cmp(r, 32'h0000_0001);
      sleep <= 1'b0;
      drain(c);
      cmp(c, 0);
      wr(`ICC_OFS_IRQ_STATUS, 32'h0000_0001);
      wr(`ICC_OFS_CONTROL, 32'h0000_0000);
      $display("power mode test done");
   endtask

   // ****
   // run control
   // ****
   task complete_run;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         complete_run;
      end
   end

   initial begin
      set_timers(16'h0000);
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_regs;
      t_timebase;
      t_modes;
      t_overflow;
      t_irq;
      t_power;
      complete_run;
   end
endmodule

`default_nettype wire
